/* verilog/program_space_access.v */
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "program_space_access_regs.vh"
module program_space_access #(
    parameter FLASH_OP_CYCLES = `FLASH_OP_CYCLES
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_reset_n,
    // axi4-lite write address
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output wire        o_awready,
    // axi4-lite write data
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output wire        o_wready,
    // axi4-lite write response
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    // axi4-lite read
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output wire        o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready,
    // cpu access request
    input  wire        i_req,
    input  wire [1:0]  i_op,
    input  wire        i_byte_mode,
    input  wire [15:0] i_ea,
    input  wire [15:0] i_wr_data,
    input  wire        i_data_read,
    input  wire        i_plain_move,
    input  wire        i_in_repeat,
    input  wire        i_repeat_edge,
    output wire        o_busy,
    output reg         o_done,
    output reg  [15:0] o_rd_data,
    output reg  [1:0]  o_extra_cycles,
    // flash array side
    output reg  [23:0] o_fa_addr,
    output reg         o_fa_rd,
    input  wire [23:0] i_fa_rdata,
    output reg         o_fa_start,
    output reg         o_fa_erase,
    output reg  [2:0]  o_fa_rows,
    output reg  [23:0] o_fa_wdata,
    output reg  [4:0]  o_fa_widx
);
    localparam OP_RD_LOW  = 2'd0;
    localparam OP_RD_HIGH = 2'd1;
    localparam OP_WR_LOW  = 2'd2;
    localparam OP_WR_HIGH = 2'd3;
    localparam ST_IDLE  = 3'd0;
    localparam ST_READ  = 3'd1;
    localparam ST_WRITE = 3'd2;
    localparam ST_FLASH = 3'd3;
    localparam ST_DUMP  = 3'd4;
    localparam CW = 24;
    localparam [CW-1:0] TW_LOAD = `TABLE_WRITE_CYCLES - 1;

    reg [2:0]    state_r;
    reg [7:0]    table_page_r;
    reg [7:0]    vis_page_r;
    reg [15:0]   core_ctrl_r;
    reg [15:0]   flash_ctrl_r;
    reg          key_first_r;
    reg          unlocked_r;
    reg [CW-1:0] count_r;
    reg [23:0]   addr_r;
    reg [1:0]    op_r;
    reg          byte_r;
    reg          vis_r;
    reg          reading_r;
    reg          refused_r;
    reg          aw_held_r;
    reg          w_held_r;
    reg [7:0]    awaddr_r;
    reg [31:0]   wdata_r;
    reg [3:0]    wstrb_r;
    reg          go_req_r;

    wire [23:0] lat_rdata;
    wire        table_op  = i_req && (state_r == ST_IDLE) && !i_data_read;
    wire        vis_hit   = i_ea[15] && core_ctrl_r[`CORE_VIS_ENABLE_BIT];
    wire        vis_op    = i_req && (state_r == ST_IDLE) && i_data_read && vis_hit;
    wire        is_write  = i_op[1];
    wire        cfg_space = table_page_r[7];
    wire        lat_we    = table_op && is_write && !cfg_space;
    wire [1:0]  lat_lane;
    wire [23:0] lat_wdata;
    wire [5:0]  opcode    = flash_ctrl_r[5:0];
    reg  [2:0]  rows_sel;
    reg         op_valid;
    reg  [7:0]  dump_idx_r;

    assign lat_lane  = (i_op == OP_WR_HIGH) ? 2'b10 : 2'b01;
    assign lat_wdata = {i_wr_data[7:0], i_wr_data};
    assign o_busy    = (state_r != ST_IDLE);
    assign o_awready = !aw_held_r;
    assign o_wready  = !w_held_r;
    assign o_arready = !o_rvalid;

    row_latch #(
        .WORDS (`ROW_WORDS),
        .AW    (5)
    ) u_latch (
        .i_clk   (i_clk),
        .i_we    (lat_we),
        .i_waddr (i_ea[5:1]),
        .i_wlane (lat_lane),
        .i_wdata (lat_wdata),
        .i_raddr (dump_idx_r[4:0]),
        .o_rdata (lat_rdata)
    );

    // erase size from low opcode bits
    always @* begin
        rows_sel = 3'd1;
        op_valid = 1'b0;
        if (flash_ctrl_r[`FC_ERASE_BIT]) begin
            if (opcode == `OP_ERASE_1ROW) begin
                rows_sel = 3'd1;
                op_valid = 1'b1;
            end else if (opcode == `OP_ERASE_2ROW) begin
                rows_sel = 3'd2;
                op_valid = 1'b1;
            end else if (opcode == `OP_ERASE_4ROW) begin
                rows_sel = 3'd4;
                op_valid = 1'b1;
            end
        end else if (opcode[5:2] == `OP_WRITE_ROW_HI) begin
            op_valid = 1'b1;
        end
    end

    // read data shaping
    function [15:0] shape;
        input [1:0]  op;
        input        bmode;
        input        bsel;
        input [23:0] w;
        begin
            if (op == OP_RD_LOW && !bmode) begin
                shape = w[15:0];
            end else if (op == OP_RD_LOW) begin
                shape = {8'h00, bsel ? w[15:8] : w[7:0]};
            end else if (!bmode) begin
                shape = {8'h00, w[23:16]};
            end else begin
                shape = {8'h00, bsel ? 8'h00 : w[23:16]};
            end
        end
    endfunction

    // bus write commit
    wire aw_ok = aw_held_r || i_awvalid;
    wire w_ok  = w_held_r || i_wvalid;
    wire [7:0]  wa = aw_held_r ? awaddr_r : i_awaddr;
    wire [31:0] wd = w_held_r ? wdata_r : i_wdata;
    wire [3:0]  ws = w_held_r ? wstrb_r : i_wstrb;
    wire commit = aw_ok && w_ok && !o_bvalid;

    always @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r        <= ST_IDLE;
            table_page_r   <= 8'h00;
            vis_page_r     <= 8'h00;
            core_ctrl_r    <= 16'h0000;
            flash_ctrl_r   <= 16'h0000;
            key_first_r    <= 1'b0;
            unlocked_r     <= 1'b0;
            count_r        <= {CW{1'b0}};
            addr_r         <= 24'h000000;
            op_r           <= 2'd0;
            byte_r         <= 1'b0;
            vis_r          <= 1'b0;
            reading_r      <= 1'b0;
            refused_r      <= 1'b0;
            aw_held_r      <= 1'b0;
            w_held_r       <= 1'b0;
            awaddr_r       <= 8'h00;
            wdata_r        <= 32'h00000000;
            wstrb_r        <= 4'h0;
            go_req_r       <= 1'b0;
            o_bvalid       <= 1'b0;
            o_bresp        <= 2'b00;
            o_rvalid       <= 1'b0;
            o_rresp        <= 2'b00;
            o_rdata        <= 32'h00000000;
            o_done         <= 1'b0;
            o_rd_data      <= 16'h0000;
            o_extra_cycles <= 2'd0;
            o_fa_addr      <= 24'h000000;
            o_fa_rd        <= 1'b0;
            o_fa_start     <= 1'b0;
            o_fa_erase     <= 1'b0;
            o_fa_rows      <= 3'd1;
            o_fa_wdata     <= 24'h000000;
            o_fa_widx      <= 5'd0;
            dump_idx_r     <= 8'h00;
        end else begin
            o_done     <= 1'b0;
            o_fa_rd    <= 1'b0;
            o_fa_start <= 1'b0;
            go_req_r   <= 1'b0;
            // axi write channels
            if (i_awvalid && !aw_held_r && !commit) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= i_awaddr;
            end
            if (i_wvalid && !w_held_r && !commit) begin
                w_held_r <= 1'b1;
                wdata_r  <= i_wdata;
                wstrb_r  <= i_wstrb;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            if (commit) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= 2'b00;
                if (wa == `REG_TABLE_PAGE) begin
                    if (ws[0]) table_page_r <= wd[7:0];
                end else if (wa == `REG_VIS_PAGE) begin
                    if (ws[0]) vis_page_r <= (wd[7:0] == `VIS_PAGE_EEPROM) ?
                        `VIS_PAGE_EEPROM : `VIS_PAGE_FLASH;
                end else if (wa == `REG_CORE_CONTROL) begin
                    if (ws[0]) core_ctrl_r[7:0] <= wd[7:0];
                    if (ws[1]) core_ctrl_r[15:8] <= wd[15:8];
                end else if (wa == `REG_FLASH_CONTROL) begin
                    if (ws[0]) flash_ctrl_r[6:0] <= wd[6:0];
                    if (ws[1]) begin
                        flash_ctrl_r[14:12] <= wd[14:12];
                        go_req_r <= wd[`FC_GO_BIT] && !flash_ctrl_r[`FC_GO_BIT];
                    end
                end else if (wa == `REG_FLASH_KEY) begin
                    key_first_r <= ws[0] && (wd[7:0] == `KEY_FIRST);
                    unlocked_r  <= ws[0] && key_first_r && (wd[7:0] == `KEY_SECOND);
                end else if (wa != `REG_STATUS) begin
                    o_bresp <= 2'b10;
                end
                if (wa != `REG_FLASH_KEY) begin
                    key_first_r <= 1'b0;
                end
            end
            // axi read
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end else if (i_arvalid && !o_rvalid) begin
                o_rvalid <= 1'b1;
                o_rresp  <= 2'b00;
                if (i_araddr == `REG_TABLE_PAGE) begin
                    o_rdata <= {24'h000000, table_page_r};
                end else if (i_araddr == `REG_VIS_PAGE) begin
                    o_rdata <= {24'h000000, vis_page_r};
                end else if (i_araddr == `REG_CORE_CONTROL) begin
                    o_rdata <= {16'h0000, core_ctrl_r};
                end else if (i_araddr == `REG_FLASH_CONTROL) begin
                    o_rdata <= {16'h0000, flash_ctrl_r};
                end else if (i_araddr == `REG_FLASH_KEY) begin
                    o_rdata <= 32'h00000000;
                end else if (i_araddr == `REG_STATUS) begin
                    o_rdata <= {29'h0, unlocked_r, refused_r, o_busy};
                end else begin
                    o_rdata <= 32'h00000000;
                    o_rresp <= 2'b10;
                end
            end
            // go request: needs wren and unlock
            if (go_req_r) begin
                unlocked_r <= 1'b0;
                if (flash_ctrl_r[`FC_WREN_BIT] && unlocked_r && op_valid &&
                        state_r == ST_IDLE) begin
                    flash_ctrl_r[`FC_GO_BIT] <= 1'b1;
                    o_fa_erase <= flash_ctrl_r[`FC_ERASE_BIT];
                    o_fa_rows  <= rows_sel;
                    o_fa_addr  <= {table_page_r, i_ea[15:8], i_ea[7] & !rows_sel[2],
                                   i_ea[6] & rows_sel[0], 6'h00};
                    addr_r     <= {table_page_r, 16'h0000};
                    dump_idx_r <= 8'h00;
                    count_r    <= FLASH_OP_CYCLES[CW-1:0];
                    state_r    <= flash_ctrl_r[`FC_ERASE_BIT] ? ST_FLASH : ST_DUMP;
                end else begin
                    flash_ctrl_r[`FC_WRERR_BIT] <= 1'b1;
                end
            end
            case (state_r)
                ST_IDLE: begin
                    if (table_op) begin
                        addr_r    <= {table_page_r, i_ea};
                        o_extra_cycles <= 2'd0;
                        op_r      <= i_op;
                        byte_r    <= i_byte_mode;
                        vis_r     <= 1'b0;
                        refused_r <= is_write && cfg_space;
                        reading_r <= !is_write;
                        o_fa_addr <= {table_page_r, i_ea[15:1], 1'b0};
                        o_fa_rd   <= !is_write;
                        count_r   <= TW_LOAD;
                        state_r   <= is_write ? ST_WRITE : ST_READ;
                    end else if (vis_op) begin
                        o_fa_addr <= {1'b0, vis_page_r, i_ea[14:1], 1'b0};
                        o_fa_rd   <= 1'b1;
                        op_r      <= OP_RD_LOW;
                        byte_r    <= 1'b0;
                        vis_r     <= 1'b1;
                        reading_r <= 1'b1;
                        if (i_in_repeat && !i_repeat_edge) begin
                            o_extra_cycles <= 2'd0;
                        end else if (i_in_repeat || !i_plain_move) begin
                            o_extra_cycles <= 2'd2;
                        end else begin
                            o_extra_cycles <= 2'd1;
                        end
                        state_r <= ST_READ;
                    end
                end
                ST_READ: begin
                    o_rd_data <= shape(op_r, byte_r, addr_r[0], i_fa_rdata);
                    o_done    <= 1'b1;
                    reading_r <= 1'b0;
                    state_r   <= ST_IDLE;
                end
                ST_WRITE: begin
                    if (count_r == {CW{1'b0}}) begin
                        o_done  <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        count_r <= count_r - 1'b1;
                    end
                end
                ST_DUMP: begin
                    // hand latch row to array, one word per cycle
                    o_fa_wdata <= lat_rdata;
                    o_fa_widx  <= dump_idx_r[4:0] - 5'd1;
                    if (dump_idx_r == `ROW_WORDS) begin
                        o_fa_start <= 1'b1;
                        state_r    <= ST_FLASH;
                    end else begin
                        dump_idx_r <= dump_idx_r + 8'd1;
                    end
                end
                ST_FLASH: begin
                    if (o_fa_erase && count_r == FLASH_OP_CYCLES[CW-1:0]) begin
                        o_fa_start <= 1'b1;
                    end
                    if (count_r == {CW{1'b0}}) begin
                        flash_ctrl_r[`FC_GO_BIT] <= 1'b0;
                        state_r <= ST_IDLE;
                    end else begin
                        count_r <= count_r - 1'b1;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* shared/program_space_access_regs.vh */
`ifndef PROGRAM_SPACE_ACCESS_REGS_VH
`define PROGRAM_SPACE_ACCESS_REGS_VH
// register byte offsets
`define REG_TABLE_PAGE      8'h00
`define REG_VIS_PAGE        8'h04
`define REG_CORE_CONTROL    8'h08
`define REG_FLASH_CONTROL   8'h0C
`define REG_FLASH_KEY       8'h10
`define REG_STATUS          8'h14
// field positions
`define CORE_VIS_ENABLE_BIT 2
`define FC_GO_BIT           15
`define FC_WREN_BIT         14
`define FC_WRERR_BIT        13
`define FC_ERASE_BIT        6
// flash control encodings
`define OP_ERASE_1ROW       6'h18
`define OP_ERASE_2ROW       6'h19
`define OP_ERASE_4ROW       6'h1A
`define OP_WRITE_ROW_HI     4'h1
`define KEY_FIRST           8'h55
`define KEY_SECOND          8'hAA
// geometry and timing
`define ROW_WORDS           32
`define VIS_PAGE_FLASH      8'h00
`define VIS_PAGE_EEPROM     8'hFF
`define TABLE_WRITE_CYCLES  2
`define FLASH_OP_TIME_NS    2000
`define CLK_PERIOD_NS       8
`define FLASH_OP_CYCLES     ((`FLASH_OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* verilog/row_latch.v */
`timescale 1ns/1ns
`default_nettype none
module row_latch #(
    parameter WORDS = 32,
    parameter AW    = 5
) (
    // clock
    input  wire          i_clk,
    // write port
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [1:0]    i_wlane,
    input  wire [23:0]   i_wdata,
    // read port
    input  wire [AW-1:0] i_raddr,
    output reg  [23:0]   o_rdata
);
    reg [23:0] mem [0:WORDS-1];
    // later writes overwrite, any order
    always @(posedge i_clk) begin
        if (i_we) begin
            if (i_wlane[0]) begin
                mem[i_waddr][15:0] <= i_wdata[15:0];
            end
            if (i_wlane[1]) begin
                mem[i_waddr][23:16] <= i_wdata[23:16];
            end
        end
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

/* testbench/program_space_access_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module psa_checker (
    // clock and reset
    input wire        i_clk,
    input wire        i_reset_n,
    // cpu side
    input wire        i_req,
    input wire [1:0]  i_op,
    input wire        i_byte_mode,
    input wire [15:0] i_ea,
    input wire        i_data_read,
    input wire        i_plain_move,
    input wire        i_in_repeat,
    input wire        i_repeat_edge,
    input wire        o_busy,
    input wire        o_done,
    input wire [15:0] o_rd_data,
    input wire [1:0]  o_extra_cycles,
    // flash side
    input wire [23:0] o_fa_addr,
    input wire        o_fa_rd,
    input wire        o_fa_start,
    input wire        o_fa_erase,
    input wire [2:0]  o_fa_rows
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    wire tk = i_req && !o_busy && !i_data_read;
    wire tbl_done = o_done && !i_data_read;

    a_read_latency: assert property (tk && !i_op[1] |=> o_fa_rd ##1 o_done)
        else $error("read late");
    a_write_latency: assert property (tk && i_op[1] |=> !o_done [*2] ##1 o_done)
        else $error("write time");
    a_write_no_array: assert property (tk && i_op[1] |=> (!o_fa_rd && !o_fa_start) [*3])
        else $error("write hit array");
    a_low_byte: assert property (tbl_done && i_op == 2'd0 && i_byte_mode
        |-> o_rd_data[15:8] == 8'h00)
        else $error("byte low upper");
    a_high_word: assert property (tbl_done && i_op == 2'd1 |-> o_rd_data[15:8] == 8'h00)
        else $error("phantom set");
    a_phantom_zero: assert property (tbl_done && i_op == 2'd1 && i_byte_mode && i_ea[0]
        |-> o_rd_data == 16'h0000)
        else $error("phantom sel set");
    a_table_addr: assert property (o_fa_rd && !i_data_read
        |-> o_fa_addr[15:1] == i_ea[15:1])
        else $error("table addr");
    a_vis_addr: assert property (o_fa_rd && i_data_read
        |-> o_fa_addr[14:1] == i_ea[14:1] && !o_fa_addr[23])
        else $error("vis addr");
    a_vis_gate: assert property (i_req && !o_busy && i_data_read && !i_ea[15]
        |=> !o_fa_rd)
        else $error("vis gate");
    a_vis_cost: assert property (o_done && i_data_read |-> o_extra_cycles ==
        (i_in_repeat ? (i_repeat_edge ? 2'd2 : 2'd0) : (i_plain_move ? 2'd1 : 2'd2)))
        else $error("vis cost");
    a_table_cost: assert property (tbl_done |-> o_extra_cycles == 2'd0)
        else $error("table cost");
    a_erase_rows: assert property (o_fa_start && o_fa_erase
        |-> o_fa_rows == 3'd1 || o_fa_rows == 3'd2 || o_fa_rows == 3'd4)
        else $error("erase size");
    a_go_stalls: assert property (o_fa_start |-> o_busy ##1 o_busy)
        else $error("no stall");

    c_erase: cover property (o_fa_start && o_fa_erase);
    c_program: cover property (o_fa_start && !o_fa_erase);
    c_vis_repeat: cover property (o_done && i_data_read && i_in_repeat);
endmodule
bind program_space_access psa_checker psa_checker_i (.*);
`default_nettype wire

/* testbench/flash_array_model.sv */
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
    // clock
    input  wire         i_clk,
    // read port
    input  wire  [23:0] i_addr,
    input  wire         i_rd,
    output logic [23:0] o_rdata,
    // program port
    input  wire         i_start,
    input  wire         i_erase,
    input  wire  [2:0]  i_rows,
    input  wire  [23:0] i_wdata,
    input  wire  [4:0]  i_widx
);
    logic        rd_q = 1'b0;
    logic [23:0] last_r = 24'h000000;
    logic [23:0] shadow [32];
    logic [23:0] row_img [32];
    logic        last_erase;
    logic [2:0]  last_rows;
    int          start_cnt = 0;
    assign o_rdata = (i_rd || rd_q) ?
        {i_addr[8:1] ^ i_addr[23:16] ^ 8'h96, i_addr[16:1] ^ 16'h5AC3} : ~last_r;
    always @(posedge i_clk) begin
        rd_q <= i_rd;
        last_r <= o_rdata;
        shadow[i_widx] <= i_wdata;
        if (i_start) begin
            start_cnt <= start_cnt + 1;
            last_erase <= i_erase;
            last_rows <= i_rows;
            if (!i_erase) begin
                row_img <= shadow;
                row_img[i_widx] <= i_wdata;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        i_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        i_req, i_byte_mode, i_data_read, i_plain_move, i_in_repeat, i_repeat_edge;
    logic [7:0]  i_awaddr, i_araddr, tpg, vpg;
    logic [31:0] i_wdata, rv;
    logic [3:0]  i_wstrb;
    logic [1:0]  i_op, rr;
    logic [15:0] i_ea, i_wr_data, lfsr_r;
    logic [23:0] lat [32];
    logic [23:1] seen_a;
    wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy, o_done;
    wire         o_fa_rd, o_fa_start, o_fa_erase;
    wire [1:0]   o_bresp, o_rresp, o_extra_cycles;
    wire [31:0]  o_rdata;
    wire [15:0]  o_rd_data;
    wire [23:0]  o_fa_addr, i_fa_rdata, o_fa_wdata;
    wire [2:0]   o_fa_rows;
    wire [4:0]   o_fa_widx;
    typedef struct {logic [15:0] d; logic [1:0] x; logic [23:1] a; bit r;} note_t;
    note_t       q [$];
    note_t       nm;
    int          num_errors = 0;
    int          n_tests = 0;

    program_space_access #(.FLASH_OP_CYCLES(5)) program_space_access_i (.*);
    flash_array_model flash_array_model_i (.i_clk(i_clk), .i_addr(o_fa_addr), .i_rd(o_fa_rd),
        .o_rdata(i_fa_rdata), .i_start(o_fa_start), .i_erase(o_fa_erase), .i_rows(o_fa_rows),
        .i_wdata(o_fa_wdata), .i_widx(o_fa_widx));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    function automatic logic [15:0] rnd();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return lfsr_r;
    endfunction
    function automatic logic [23:0] pat(input logic [23:0] a);
        return {a[8:1] ^ a[23:16] ^ 8'h96, a[16:1] ^ 16'h5AC3};
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        bit ha, hw, hb;
        {i_awaddr, i_wdata, i_awvalid, i_wvalid} <= {a, d, 2'b11};
        while (!hb) begin
            @(negedge i_clk);
            {ha, hw, hb, rr} = {i_awvalid && o_awready, i_wvalid && o_wready, o_bvalid, o_bresp};
            @(posedge i_clk);
            if (ha) i_awvalid <= 1'b0;
            if (hw) i_wvalid <= 1'b0;
        end
        chk("bresp", 32'(rr), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a);
        bit ha, hr;
        {i_araddr, i_arvalid} <= {a, 1'b1};
        while (!hr) begin
            @(negedge i_clk);
            {ha, hr, rv, rr} = {i_arvalid && o_arready, o_rvalid, o_rdata, o_rresp};
            @(posedge i_clk);
            if (ha) i_arvalid <= 1'b0;
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er = 2'h0);
        rd(a);
        chk("rdata", rv & m, e);
        chk("rresp", 32'(rr), 32'(er));
    endtask
    task automatic pg(input logic [7:0] p);
        tpg = p;
        wr(8'h00, 32'(p));
    endtask

    task automatic cpu(input logic [1:0] op, input logic bm, input logic [15:0] ea, wd,
                       input logic [3:0] f, input note_t t, input bit nt = 1'b1);
        bit b;
        int c;
        if (nt) q.push_back(t);
        {i_op, i_byte_mode, i_ea, i_wr_data} <= {op, bm, ea, wd};
        {i_data_read, i_plain_move, i_in_repeat, i_repeat_edge} <= f;
        i_req <= 1'b1;
        b = 1'b1;
        for (int n = 0; n < 50 && b; n++) begin
            @(negedge i_clk);
            b = o_busy || (!nt && n < 3);
            c += (o_fa_rd === 1'b1 || o_done === 1'b1);
            @(posedge i_clk);
        end
        i_req <= 1'b0;
        while (nt && !b) begin
            @(negedge i_clk);
            b = o_done;
            @(posedge i_clk);
        end
        if (!nt) chk("ignored", 32'(c), 32'h0);
    endtask
    task automatic trd(input logic [1:0] op, input logic bm, input logic [15:0] ea);
        logic [23:0] w;
        note_t t;
        w = pat({tpg, ea});
        t = '{16'h0000, 2'h0, {tpg, ea[15:1]}, 1'b1};
        if (op == 2'h0) t.d = !bm ? w[15:0] : {8'h00, ea[0] ? w[15:8] : w[7:0]};
        else t.d = (bm && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
        cpu(op, bm, ea, 16'h0000, 4'h0, t);
    endtask
    task automatic twr(input logic hi, input logic [15:0] ea, d);
        if (!tpg[7] && hi) lat[ea[5:1]][23:16] = d[7:0];
        if (!tpg[7] && !hi) lat[ea[5:1]][15:0] = d;
        cpu({1'b1, hi}, 1'b0, ea, d, 4'h0, '{16'h0000, 2'h0, 23'h0, 1'b0});
    endtask
    task automatic vrd(input logic [15:0] ea, input logic [2:0] f, input logic [1:0] x);
        logic [23:0] w;
        w = pat({1'b0, vpg, ea[14:0]});
        cpu(2'h0, 1'b0, ea, 16'h0000, {1'b1, f}, '{w[15:0], x, {1'b0, vpg, ea[14:1]}, 1'b1});
    endtask
    task automatic fgo(input logic [5:0] op, input logic er);
        int c0;
        c0 = flash_array_model_i.start_cnt;
        wr(8'h10, 32'h0000_0055);
        wr(8'h10, 32'h0000_00AA);
        wr(8'h0C, 32'h0000_C000 | 32'(er) << 6 | 32'(op));
        rchk(8'h0C, 32'h0000_8000, 32'h0000_8000);
        for (int n = 0; n < 100 && rv[15]; n++) rd(8'h0C);
        chk("go_clear", 32'(rv[15]), 32'h0);
        chk("starts", flash_array_model_i.start_cnt, c0 + 1);
        chk("erase", 32'(flash_array_model_i.last_erase), 32'(er));
    endtask

    always @(negedge i_clk) begin
        if (o_fa_rd === 1'b1) seen_a = o_fa_addr[23:1];
        if (o_done === 1'b1 && q.size() == 0) chk("note_queue", 32'h0, 32'h1);
        else if (o_done === 1'b1) begin
            nm = q.pop_front();
            chk("extra", 32'(o_extra_cycles), 32'(nm.x));
            if (nm.r) chk("rd_data", 32'(o_rd_data), 32'(nm.d));
            if (nm.r) chk("fa_addr", 32'(seen_a), 32'(nm.a));
        end
    end

    initial begin
        #(8 * 60000);
        num_errors++;
        final_report();
    end

    initial begin
        {i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_req} = 7'h0A;
        {i_byte_mode, i_data_read, i_plain_move, i_in_repeat, i_repeat_edge} = 5'h00;
        {i_awaddr, i_araddr, i_wdata, i_op, i_ea, i_wr_data} = 82'h0;
        {i_wstrb, lfsr_r, tpg, vpg} = {4'hF, 16'h003D, 16'h0000};
        repeat (5) @(posedge i_clk);
        i_reset_n <= 1'b1;
        @(posedge i_clk);
        for (int k = 0; k < 6; k++) rchk(8'(k * 4), 32'h0, 32'hFFFF_FFFF);
        rchk(8'h20, 32'h0, 32'hFFFF_FFFF, 2'h2);
        wr(8'h20, 32'h1, 2'h2);
        pg(8'h01);
        for (int k = 0; k < 8; k++) trd({1'b0, k[2]}, k[1], {rnd() | 16'h0001} ^ 16'(!k[0]));
        pg(8'h02);
        for (int k = 31; k >= 0; k--) begin
            twr(1'b0, 16'(k * 2), rnd());
            twr(1'b1, 16'(k * 2), rnd() & 16'h0001 ? 16'h00FF : 16'h0000);
        end
        twr(1'b0, 16'h0006, 16'hBEEF);
        pg(8'h80);
        trd(2'h0, 1'b0, 16'h0006);
        twr(1'b0, 16'h000A, 16'h1234);
        rchk(8'h14, 32'h2, 32'h2);
        pg(8'h02);
        fgo(6'h04, 1'b0);
        for (int k = 0; k < 32; k++) chk("row", 32'(flash_array_model_i.row_img[k]), 32'(lat[k]));
        for (int k = 0; k < 3; k++) begin
            fgo(6'h18 + 6'(k), 1'b1);
            chk("rows", 32'(flash_array_model_i.last_rows), 32'(1 << k));
        end
        wr(8'h0C, 32'h0000_C004);
        rchk(8'h0C, 32'h0000_2000, 32'h0000_A000);
        wr(8'h0C, 32'h0);
        cpu(2'h0, 1'b0, 16'h8010, 16'h0000, 4'h8, '{16'h0, 2'h0, 23'h0, 1'b0}, 1'b0);
        wr(8'h08, 32'h4);
        cpu(2'h0, 1'b0, 16'h0010, 16'h0000, 4'h8, '{16'h0, 2'h0, 23'h0, 1'b0}, 1'b0);
        wr(8'h04, 32'h12);
        rchk(8'h04, 32'h0, 32'hFF);
        vrd(16'h8124, 3'h4, 2'h1);
        vrd(16'h8FFE, 3'h0, 2'h2);
        vrd(16'hC002, 3'h3, 2'h2);
        vrd(16'hC004, 3'h2, 2'h0);
        trd(2'h0, 1'b0, 16'h8002);
        vpg = 8'hFF;
        wr(8'h04, 32'hFF);
        rchk(8'h04, 32'hFF, 32'hFF);
        vrd(16'h8004, 3'h4, 2'h1);
        final_report();
    end
endmodule
`default_nettype wire
